//--- hdl/ostc_pkg.sv
package ostc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 25000000;             // system clock rate
  localparam int unsigned TICK_HZ       = 1000;                 // 1 ms timer resolution
  localparam int unsigned TICK_CYC      = CLK_HZ / TICK_HZ;     // cycles per ms tick
  localparam int unsigned CLUTCH_MS     = 3500;                 // clutch hold after trail
  localparam int unsigned LIFT_MS       = 6000;                 // lifter timeout
  localparam int unsigned LOWER_MS      = 30;                   // lowering step
  localparam int unsigned DEFLECT_MS    = 300;                  // deflector delay
  localparam int unsigned MS_W          = 13;                   // ms counter width

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] A_CTRL   = 8'h00;  // command / routing
  localparam logic [7:0] A_STAT   = 8'h04;  // live state
  localparam logic [7:0] A_IRQ    = 8'h08;  // sticky events, w1c
  localparam logic [7:0] A_MASK   = 8'h0c;  // event mask
  localparam int unsigned CTRL_START = 0;   // write 1: drive start pulse
  localparam int unsigned CTRL_ERR   = 1;   // route to error tray
  localparam int unsigned CTRL_LARGE = 2;   // large paper size
  localparam int unsigned EV_W       = 4;   // number of event bits
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic lift_fault;    // lifter timed out
    logic tray_full;     // capacity switch closed
    logic deflect_ok;    // error tray sensor confirmed
    logic page_clear;    // print cleared delivery sensor
  } ostc_ev_t;

  typedef struct packed {
    logic switchback_exit_sensor;
    logic main_delivery_sensor;
    logic stack_level_sensor;
    logic small_paper_full_switch;
    logic large_paper_full_switch;
    logic tray_empty_sensor;
    logic error_tray_sensor;
  } ostc_sens_t;

  typedef enum logic [4:0] {
    LS_IDLE  = 5'h01,  // brake holds, motor off
    LS_RISE  = 5'h02,  // lifting toward level sensor
    LS_LOWER = 5'h04,  // short lowering step
    LS_HOLD  = 5'h08,  // braked, stacking
    LS_FULL  = 5'h10   // full or faulted, waits for start
  } ostc_lift_t;

endpackage : ostc_pkg

//--- hdl/ostc_sync.sv
`timescale 1ns/10ps
// ****************************************
// two-flop synchroniser, one per bit
// ****************************************
module ostc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;  // first stage, read only by q

  // two stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : ostc_sync

//--- hdl/ostc_timer.sv
`timescale 1ns/10ps
// ****************************************
// millisecond down-counter, pulses done once
// ****************************************
module ostc_timer
  import ostc_pkg::*;
(
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // control
  input  wire logic            tick,   // 1 ms strobe
  input  wire logic            load,   // start or restart
  input  wire logic            stop,   // abandon
  input  wire logic [MS_W-1:0] ms,     // duration in ms
  output logic                 done    // one-cycle pulse
);
  logic [MS_W-1:0] cnt_r;  // remaining ms
  logic            run_r;  // counting

  // count down on ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_r <= ms;
        run_r <= 1'b1;
      end else if (stop) begin
        run_r <= 1'b0;
      end else if (run_r && tick) begin
        if (cnt_r <= MS_W'(1)) begin
          run_r <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_r <= cnt_r - MS_W'(1);
        end
      end
    end
  end
endmodule : ostc_timer

//--- hdl/ostc_top.sv
`timescale 1ns/10ps
// How it works
// [R1] main-tray print: deflector stays off
// [R2] delivery sensor sees print: clutch on
// [R3] clutch off 3.5 s after trailing edge
// [R4] printer discards page once sensor clears
// [R5] start: brake released, motor up
// [R6] level sensor active: motor off
// [R7] no level after 6 s: report fault
// [R8] lower 0.03 s, then brake on
// [R9] level active again: repeat lowering step
// [R10] size picks small or large switch
// [R11] full switch: report full, stop motor
// [R12] printer restarts tray after emptying
// [R13] error print: deflector on after 0.3 s
// [R14] error tray sensor confirms diversion
// [R15] printer says which tray per print
// [R16] all timing from 1 ms clock counters
// [R17] after full, rise only on new start
module ostc_top
  import ostc_pkg::*;
(
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // axi4-lite write address
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  // axi4-lite write response
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // sensors from pins
  input  wire ostc_pkg::ostc_sens_t sens,
  // actuators
  output logic                 error_deflect_solenoid,
  output logic                 delivery_clutch,
  output logic                 tray_brake_solenoid,
  output logic                 tray_lift_motor_up,
  output logic                 tray_lift_motor_down,
  // interrupt
  output logic                 irq
);

  // ****************************************
  // sensor synchronisation and edges
  // ****************************************
  ostc_sens_t s;         // synchronised sensors
  ostc_sens_t s_d_r;     // previous sample

  ostc_sync #(.W($bits(ostc_sens_t))) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (sens),
    .q       (s)
  );

  // edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) s_d_r <= '0;
    else          s_d_r <= s;
  end

  logic sb_fall;    // print cleared switchback exit
  logic md_rise;    // print reached delivery sensor
  logic md_fall;    // trailing edge cleared delivery
  logic lvl_rise;   // level sensor came on
  logic et_rise;    // error tray sensor hit
  assign sb_fall  = s_d_r.switchback_exit_sensor & ~s.switchback_exit_sensor;
  assign md_rise  = ~s_d_r.main_delivery_sensor & s.main_delivery_sensor;
  assign md_fall  = s_d_r.main_delivery_sensor & ~s.main_delivery_sensor;
  assign lvl_rise = ~s_d_r.stack_level_sensor & s.stack_level_sensor;
  assign et_rise  = ~s_d_r.error_tray_sensor & s.error_tray_sensor;

  // ****************************************
  // millisecond tick
  // ****************************************
  logic [15:0] pre_r;  // prescaler
  logic        tick_r; // 1 ms strobe

  // divide clock to 1 ms [R16]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r  <= '0;
      tick_r <= 1'b0;
    end else if (pre_r == 16'(TICK_CYC - 1)) begin
      pre_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      pre_r  <= pre_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  logic            aw_hold_r, w_hold_r;  // captured halves
  logic [7:0]      awaddr_r;             // held write address
  logic [31:0]     wdata_r;              // held write data
  logic [3:0]      wstrb_r;              // held strobes
  logic            err_route_r;          // route to error tray
  logic            large_r;              // large paper size
  logic            start_p;              // drive start pulse
  logic [EV_W-1:0] ev_r, mask_r;         // sticky events, mask
  logic            wr_go;                // both halves present
  ostc_ev_t        ev_set;               // this cycle's events
  ostc_lift_t      st_r;                 // lifter state

  assign wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == A_CTRL || awaddr_r == A_IRQ || awaddr_r == A_MASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register and start pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_route_r <= 1'b0;
      large_r     <= 1'b0;
      start_p     <= 1'b0;
      mask_r      <= EV_RST;
    end else begin
      start_p <= 1'b0;
      if (wr_go && wstrb_r[0]) begin
        if (awaddr_r == A_CTRL) begin
          start_p     <= wdata_r[CTRL_START];
          err_route_r <= wdata_r[CTRL_ERR];    // [R15]
          large_r     <= wdata_r[CTRL_LARGE];
        end
        if (awaddr_r == A_MASK) mask_r <= wdata_r[EV_W-1:0];
      end
    end
  end

  // sticky events, set wins over write-one-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_r <= EV_RST;
    end else if (wr_go && wstrb_r[0] && awaddr_r == A_IRQ) begin
      ev_r <= (ev_r & ~wdata_r[EV_W-1:0]) | ev_set;
    end else begin
      ev_r <= ev_r | ev_set;
    end
  end

  // irq level
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else          irq <= |((ev_r | ev_set) & mask_r);
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          A_CTRL:  s_axi_rdata <= {29'h0, large_r, err_route_r, 1'b0};
          A_STAT:  s_axi_rdata <= {20'h0, s, st_r};
          A_IRQ:   s_axi_rdata <= {28'h0, ev_r};
          A_MASK:  s_axi_rdata <= {28'h0, mask_r};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // delivery path
  // ****************************************
  logic clutch_done, defl_done, lower_done, lift_done;
  logic full_sw;   // applicable capacity switch

  // hold clutch 3.5 s after the trailing edge
  ostc_timer u_clutch (
    .aclk (aclk), .aresetn (aresetn), .tick (tick_r),
    .load (md_fall), .stop (md_rise),
    .ms (MS_W'(CLUTCH_MS)), .done (clutch_done)
  );

  // clutch drive
  always_ff @(posedge aclk) begin
    if (!aresetn)         delivery_clutch <= 1'b0;
    else if (md_rise)     delivery_clutch <= 1'b1;  // [R2]
    else if (clutch_done) delivery_clutch <= 1'b0;  // [R3]
  end

  // deflector delay only for error-tray prints
  ostc_timer u_defl (
    .aclk (aclk), .aresetn (aresetn), .tick (tick_r),
    .load (sb_fall & err_route_r), .stop (1'b0),
    .ms (MS_W'(DEFLECT_MS)), .done (defl_done)
  );

  // deflector drive, released when the error tray sees paper
  always_ff @(posedge aclk) begin
    if (!aresetn)                          error_deflect_solenoid <= 1'b0;
    else if (defl_done)                    error_deflect_solenoid <= 1'b1;  // [R13]
    else if (et_rise || (sb_fall && !err_route_r)) error_deflect_solenoid <= 1'b0;  // [R14] [R1]
  end

  // ****************************************
  // lifter
  // ****************************************
  assign full_sw = large_r ? s.large_paper_full_switch : s.small_paper_full_switch;  // [R10]

  ostc_timer u_lift (
    .aclk (aclk), .aresetn (aresetn), .tick (tick_r),
    .load (start_p), .stop (st_r != LS_RISE),
    .ms (MS_W'(LIFT_MS)), .done (lift_done)
  );
  ostc_timer u_lower (
    .aclk (aclk), .aresetn (aresetn), .tick (tick_r),
    .load ((st_r == LS_RISE && s.stack_level_sensor) || (st_r == LS_HOLD && lvl_rise)),
    .stop (1'b0), .ms (MS_W'(LOWER_MS)), .done (lower_done)
  );

  // lifter sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= LS_IDLE;
    end else if (start_p) begin
      st_r <= LS_RISE;                                   // [R5] [R17]
    end else begin
      case (st_r)
        LS_RISE: begin
          if (full_sw)                    st_r <= LS_FULL;   // [R11]
          else if (s.stack_level_sensor)  st_r <= LS_LOWER;  // [R6]
          else if (lift_done)             st_r <= LS_FULL;   // [R7]
        end
        LS_LOWER: begin
          if (full_sw)         st_r <= LS_FULL;   // [R11]
          else if (lower_done) st_r <= LS_HOLD;   // [R8]
        end
        LS_HOLD: begin
          if (full_sw)       st_r <= LS_FULL;     // [R11]
          else if (lvl_rise) st_r <= LS_LOWER;    // [R9]
        end
        LS_IDLE, LS_FULL: st_r <= st_r;           // [R17]
        default: st_r <= LS_IDLE;
      endcase
    end
  end

  // actuator outputs from state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tray_brake_solenoid  <= 1'b0;
      tray_lift_motor_up   <= 1'b0;
      tray_lift_motor_down <= 1'b0;
    end else begin
      tray_brake_solenoid  <= (st_r == LS_RISE) || (st_r == LS_LOWER);  // [R5] [R8]
      tray_lift_motor_up   <= (st_r == LS_RISE) && !s.stack_level_sensor && !full_sw;  // [R6]
      tray_lift_motor_down <= (st_r == LS_LOWER) && !full_sw;  // [R8]
    end
  end

  // ****************************************
  // status events
  // ****************************************
  always_comb begin
    ev_set            = '0;
    ev_set.page_clear = md_fall;                          // [R4]
    ev_set.deflect_ok = et_rise;                          // [R14]
    ev_set.tray_full  = full_sw && (st_r == LS_RISE || st_r == LS_LOWER || st_r == LS_HOLD);  // [R11]
    ev_set.lift_fault = (st_r == LS_RISE) && lift_done && !s.stack_level_sensor && !full_sw;  // [R7]
  end

endmodule : ostc_top

//--- sim/ostc_checker.sv
`timescale 1ns/10ps
// ****************************************
// stacker pin and lifter checks
// ****************************************
module ostc_checker
  import ostc_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // sensors and actuators
  input wire ostc_pkg::ostc_sens_t sens,
  input wire logic        error_deflect_solenoid,
  input wire logic        delivery_clutch,
  input wire logic        tray_brake_solenoid,
  input wire logic        tray_lift_motor_up,
  input wire logic        tray_lift_motor_down,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  localparam int HOLD_C = 87475000;  // 3499 ms of cycles, one tick slack
  localparam int DEFL_C = 7475000;   // 299 ms of cycles, one tick slack
  logic [26:0] low_r;                // cycles since delivery sensor cleared
  logic [22:0] swb_r;                // cycles since switchback cleared
  // quiet time after the trailing edge
  always_ff @(posedge aclk) begin
    if (!aresetn || sens.main_delivery_sensor) low_r <= '0;
    else if (~&low_r) low_r <= low_r + 27'h1;
  end
  // quiet time after the switchback exit
  always_ff @(posedge aclk) begin
    if (!aresetn || sens.switchback_exit_sensor) swb_r <= '0;
    else if (~&swb_r) swb_r <= swb_r + 23'h1;
  end
  // level sensor arrives while lifting
  sequence s_lvl_hit;
    $rose(sens.stack_level_sensor) ##0 tray_lift_motor_up;
  endsequence
  // either full switch closes while the other is closed
  sequence s_full_hit;
    ($rose(sens.small_paper_full_switch) && sens.large_paper_full_switch) ||
    ($rose(sens.large_paper_full_switch) && sens.small_paper_full_switch);
  endsequence
  a_level_stops: assert property (s_lvl_hit |-> ##5 !tray_lift_motor_up)
    else $error("lift motor kept rising at level");
  a_lower_step: assert property (s_lvl_hit |-> ##5 (tray_lift_motor_down && tray_brake_solenoid))
    else $error("no lowering step after level");
  a_motor_brake: assert property ((tray_lift_motor_up || tray_lift_motor_down) |-> tray_brake_solenoid)
    else $error("motor driven against brake");
  a_motor_excl: assert property (!(tray_lift_motor_up && tray_lift_motor_down))
    else $error("motor up and down together");
  a_full_stop: assert property (s_full_hit |-> ##5 !(tray_lift_motor_up || tray_lift_motor_down))
    else $error("motor running on full tray");
  a_clutch_on: assert property ($rose(sens.main_delivery_sensor) |-> ##5 delivery_clutch)
    else $error("clutch not engaged");
  a_clutch_hold: assert property ($fell(delivery_clutch) |-> low_r >= HOLD_C)
    else $error("clutch released early");
  a_defl_delay: assert property ($rose(error_deflect_solenoid) |-> swb_r >= DEFL_C)
    else $error("deflector energised early");
  a_defl_drop: assert property ($rose(sens.error_tray_sensor) |-> ##5 !error_deflect_solenoid)
    else $error("deflector held after diversion");
  a_quiet_reset: assert property ($rose(aresetn) |-> !(tray_lift_motor_up || tray_brake_solenoid || irq))
    else $error("outputs active after reset");
endmodule : ostc_checker

//--- sim/ostc_engine.sv
`timescale 1ns/10ps
// ****************************************
// engine controller: register bus master
// ****************************************
module ostc_engine (
  // clock
  input  wire logic        aclk,
  // write side
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read side
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // command write; tray choice and restart travel here
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r,
                    output bit ok);
    ok = 0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        ok = 1;
      end
    end
  endtask : wr
  // status read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
    ok = 0;
    r = 2'h3;
    d = '0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        ok = 1;
      end
    end
  endtask : rd
endmodule : ostc_engine

//--- sim/ostc_top_bench.sv
`timescale 1ns/10ps
// ****************************************
// stacker bench
// ****************************************
module ostc_top_bench;
  import ostc_pkg::*;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  ostc_sens_t  sens;
  logic        error_deflect_solenoid, delivery_clutch, tray_brake_solenoid;
  logic        tray_lift_motor_up, tray_lift_motor_down, irq;
  int          miscompares, checked;
  ostc_top    dut_u (.*);
  ostc_engine eng_u (.*);
  // 25 mhz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit         ok;
    eng_u.wr(a, d, 4'hf, r, ok);
    if (!ok) begin
      miscompares++;
      end_sim();
    end
    chk(r, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    bit          ok;
    eng_u.rd(a, d, r, ok);
    if (!ok) begin
      miscompares++;
      end_sim();
    end
    chk(r, er);
    chk(d, ed);
  endtask : rd
  // reset values, refused places, mask access
  task automatic t_regs;
    logic [1:0] r;
    bit         ok;
    rd(A_CTRL, 32'h0, RESP_OKAY);
    rd(A_STAT, 32'h1, RESP_OKAY);
    rd(A_IRQ, 32'h0, RESP_OKAY);
    rd(A_MASK, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h1, RESP_SLVERR);
    wr(A_STAT, 32'hfff, RESP_SLVERR);
    rd(A_STAT, 32'h1, RESP_OKAY);
    wr(A_MASK, 32'hf, RESP_OKAY);
    rd(A_MASK, 32'hf, RESP_OKAY);
    // low strobe clear: write is answered but ignored
    eng_u.wr(A_MASK, 32'h0, 4'h0, r, ok);
    chk({ok, r}, {1'b1, RESP_OKAY});
    if (!ok) end_sim();
    rd(A_MASK, 32'hf, RESP_OKAY);
  endtask : t_regs
  // main tray print: no deflect, clutch, page clear event
  task automatic t_main;
    wr(A_CTRL, 32'h0, RESP_OKAY);
    sens.switchback_exit_sensor <= 1'b1;
    cyc(8);
    sens.switchback_exit_sensor <= 1'b0;
    cyc(40);
    chk(error_deflect_solenoid, 32'h0);
    sens.main_delivery_sensor <= 1'b1;
    cyc(8);
    chk(delivery_clutch, 32'h1);
    chk(irq, 32'h0);
    sens.main_delivery_sensor <= 1'b0;
    cyc(40);
    chk(delivery_clutch, 32'h1);
    chk(irq, 32'h1);
    rd(A_IRQ, 32'h1, RESP_OKAY);
    wr(A_IRQ, 32'h1, RESP_OKAY);
    rd(A_IRQ, 32'h0, RESP_OKAY);
    chk(irq, 32'h0);
  endtask : t_main
  // error tray confirm, masked then unmasked
  task automatic t_err;
    wr(A_MASK, 32'h0, RESP_OKAY);
    wr(A_CTRL, 32'h2, RESP_OKAY);
    sens.error_tray_sensor <= 1'b1;
    cyc(8);
    chk(error_deflect_solenoid, 32'h0);
    chk(irq, 32'h0);
    rd(A_IRQ, 32'h2, RESP_OKAY);
    wr(A_MASK, 32'h2, RESP_OKAY);
    cyc(4);
    chk(irq, 32'h1);
    sens.error_tray_sensor <= 1'b0;
    wr(A_IRQ, 32'h2, RESP_OKAY);
    wr(A_MASK, 32'hf, RESP_OKAY);
    cyc(4);
    chk(irq, 32'h0);
  endtask : t_err
  // lift, lower, full by size, restart only on start
  task automatic t_lift;
    wr(A_CTRL, 32'h1, RESP_OKAY);
    cyc(4);
    chk(tray_lift_motor_up, 32'h1);
    chk(tray_brake_solenoid, 32'h1);
    rd(A_STAT, {20'h0, sens, 5'h02}, RESP_OKAY);
    sens.stack_level_sensor <= 1'b1;
    cyc(8);
    chk(tray_lift_motor_up, 32'h0);
    chk({tray_lift_motor_down, tray_brake_solenoid}, 32'h3);
    sens.large_paper_full_switch <= 1'b1;
    cyc(8);
    rd(A_STAT, {20'h0, sens, 5'h04}, RESP_OKAY);
    sens.small_paper_full_switch <= 1'b1;
    cyc(8);
    chk({tray_lift_motor_up, tray_lift_motor_down}, 32'h0);
    chk(irq, 32'h1);
    rd(A_IRQ, 32'h4, RESP_OKAY);
    wr(A_IRQ, 32'h4, RESP_OKAY);
    sens.stack_level_sensor      <= 1'b0;
    sens.small_paper_full_switch <= 1'b0;
    sens.large_paper_full_switch <= 1'b0;
    sens.tray_empty_sensor       <= 1'b1;
    cyc(20);
    chk(tray_lift_motor_up, 32'h0);
    rd(A_STAT, {20'h0, sens, 5'h10}, RESP_OKAY);
    wr(A_CTRL, 32'h5, RESP_OKAY);
    cyc(4);
    chk(tray_lift_motor_up, 32'h1);
    sens.small_paper_full_switch <= 1'b1;
    cyc(8);
    rd(A_STAT, {20'h0, sens, 5'h02}, RESP_OKAY);
    sens.large_paper_full_switch <= 1'b1;
    cyc(8);
    chk(tray_lift_motor_up, 32'h0);
    rd(A_STAT, {20'h0, sens, 5'h10}, RESP_OKAY);
    rd(A_IRQ, 32'h4, RESP_OKAY);
  endtask : t_lift
  // main sequence
  initial begin
    miscompares = 0;
    checked = 0;
    aresetn = 1'b0;
    sens = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_main();
    t_err();
    t_lift();
    end_sim();
  end
endmodule : ostc_top_bench

bind ostc_top ostc_checker chk_u (.*);
